/* core/kms_defs.svh */
// Purpose: timing counts, offsets and reset values of the keyboard synthesizer
// Assumes: core clock of 100 MHz
// Notes: definitions only
`ifndef KMS_DEFS_SVH
`define KMS_DEFS_SVH
// ==========================================================
// clock and timing
`define KMS_CLK_KHZ 100000
`define KMS_DEMO_STEP_MS 250
`define KMS_DEMO_STEP_CYCLES (`KMS_DEMO_STEP_MS * `KMS_CLK_KHZ)
`define KMS_BCLK_HALF 5'h10
`define KMS_PIX_DIV 2'h3
// ==========================================================
// vga 640x480 frame
`define KMS_H_TOTAL 10'h31F
`define KMS_H_SYNC_ON 10'h290
`define KMS_H_SYNC_OFF 10'h2F0
`define KMS_H_VISIBLE 10'h280
`define KMS_V_TOTAL 10'h20C
`define KMS_V_SYNC_ON 10'h1EA
`define KMS_V_SYNC_OFF 10'h1EC
`define KMS_KEY_TOP 10'h0C8
`define KMS_KEY_BOT 10'h12C
// ==========================================================
// register map
`define KMS_ADDR_CTRL 6'h00
`define KMS_ADDR_STATUS 6'h04
`define KMS_ADDR_DEMO 6'h08
`define KMS_CTRL_REPLAY 0
`define KMS_CTRL_MUTE 1
`define KMS_CTRL_RESET 2'h0
// ==========================================================
// audio levels and scan codes
`define KMS_SQ_HIGH 16'h2000
`define KMS_SQ_LOW 16'hE000
`define KMS_PS2_BREAK 8'hF0
`define KMS_NUM_KEYS 19
`define KMS_DEMO_LEN 16
`endif

/* core/kms_pkg.sv */
// Purpose: shared types of the keyboard synthesizer
// Assumes: nothing
// Notes: note index 0 means silence
package kms_pkg;
  typedef logic [4:0] kms_note_t;
  typedef enum logic {KMS_BRASS, KMS_STRING} kms_timbre_t;
  typedef logic signed [15:0] kms_sample_t;
endpackage

/* core/kms_note_if.sv */
// Purpose: note request and sample return between control and synth core
// Assumes: one clock
// Notes: none
interface kms_note_if;
  import kms_pkg::*;
  kms_note_t note;
  kms_timbre_t timbre;
  kms_sample_t sample;
  modport src(output note, output timbre, input sample);
  modport synth(input note, input timbre, output sample);
endinterface

/* core/kms_timbre_synth_core.sv */
// Purpose: phase accumulator timbre_synth_core with two timbres
// Assumes: note and timbre stable from logic on the same clock
// Notes: output is zero while no note is active
`include "kms_defs.svh"
module kms_timbre_synth_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstN,
  // note port
  kms_note_if.synth noteIf
);
  import kms_pkg::*;
  logic [31:0] phase_r;
  logic [31:0] step;

  function automatic logic [31:0] stepOf(input kms_note_t n);
    logic [31:0] s;
    s = 32'h0;
    unique case (n)
      5'h01: s = 32'h1F0A;
      5'h02: s = 32'h20E2;
      5'h03: s = 32'h22E5;
      5'h04: s = 32'h24E9;
      5'h05: s = 32'h2717;
      5'h06: s = 32'h2971;
      5'h07: s = 32'h2BF5;
      5'h08: s = 32'h2E79;
      5'h09: s = 32'h3153;
      5'h0A: s = 32'h342D;
      5'h0B: s = 32'h375D;
      5'h0C: s = 32'h3A8D;
      5'h0D: s = 32'h3E13;
      5'h0E: s = 32'h41C4;
      5'h0F: s = 32'h45A0;
      5'h10: s = 32'h49D2;
      5'h11: s = 32'h4E2F;
      5'h12: s = 32'h52E1;
      5'h13: s = 32'h57BF;
      default: s = 32'h0;
    endcase
    return s;
  endfunction

  assign step = stepOf(noteIf.note);

  // ==========================================================
  // phase
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      phase_r <= 32'h0;
    end else if (noteIf.note == 5'h00) begin
      phase_r <= 32'h0;
    end else begin
      phase_r <= phase_r + step;
    end
  end

  // ==========================================================
  // waveform: brass is a square, string is a half-level sawtooth
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      noteIf.sample <= 16'h0000;
    end else if (noteIf.note == 5'h00) begin
      noteIf.sample <= 16'h0000;
    end else if (noteIf.timbre == KMS_STRING) begin
      noteIf.sample <= $signed({{2{~phase_r[31]}}, phase_r[30:17]});
    end else begin
      noteIf.sample <= phase_r[31] ? `KMS_SQ_LOW : `KMS_SQ_HIGH;
    end
  end
endmodule

/* core/kms_top.sv */
// Purpose: keyboard music synthesizer with demo melody, codec stream and key picture
// Assumes: 100 MHz core_clk; codec takes left-justified 16-bit samples in 64-bit frames
// Notes: switch, button and ps2 pins pass two flip-flops before use; axi4-lite pins are used directly
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`include "kms_defs.svh"
module kms_top #(
  parameter int DEMO_STEP_CYCLES = `KMS_DEMO_STEP_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // switches and buttons
  input wire logic timbre_select_switch,
  input wire logic source_select_switch,
  input wire logic channel_one_enable_switch,
  input wire logic channel_two_enable_switch,
  input wire logic replayBtn_b,
  // keyboard_input_decoder
  input wire logic ps2Clk,
  input wire logic ps2Data,
  // audio codec
  output logic audBclk,
  output logic audLrck,
  output logic audDacData,
  // vga
  output logic vgaHsync,
  output logic vgaVsync,
  output logic vgaRed,
  output logic vgaGreen,
  output logic vgaBlue,
  // axi4-lite
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import kms_pkg::*;
  if (DEMO_STEP_CYCLES < 2) begin : gBadStep
    $error("demo step too short");
  end

  // ==========================================================
  // reset release and pin synchronisers
  logic [1:0] rstSync_r;
  logic rstN;
  localparam int NPIN = 7;
  logic [NPIN-1:0] pinRaw, pinS1_r, pinS2_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];
  assign pinRaw = {timbre_select_switch, source_select_switch, channel_one_enable_switch,
                   channel_two_enable_switch, replayBtn_b, ps2Clk, ps2Data};
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      // replay and ps2 lines idle high: no false edge at release
      pinS1_r <= 7'h07;
      pinS2_r <= 7'h07;
    end else begin
      pinS1_r <= pinRaw;
      pinS2_r <= pinS1_r;
    end
  end
  logic timbreSw, sourceSw, chOneSw, chTwoSw, replayS_b, ps2ClkS, ps2DataS;
  assign {timbreSw, sourceSw, chOneSw, chTwoSw, replayS_b, ps2ClkS, ps2DataS} = pinS2_r;

  // ==========================================================
  // ps2 receiver and key map
  logic ps2ClkD_r, breakPend_r;
  logic [10:0] ps2Shift_r;
  logic [3:0] ps2Bits_r;
  logic [`KMS_NUM_KEYS-1:0] pressed_r;
  kms_note_t keyIdx;
  function automatic kms_note_t keyOf(input logic [7:0] c);
    kms_note_t n;
    n = 5'h00;
    unique case (c)
      8'h15: n = 5'h01;
      8'h1C: n = 5'h02;
      8'h1D: n = 5'h03;
      8'h1B: n = 5'h04;
      8'h24: n = 5'h05;
      8'h23: n = 5'h06;
      8'h2B: n = 5'h07;
      8'h2C: n = 5'h08;
      8'h34: n = 5'h09;
      8'h35: n = 5'h0A;
      8'h33: n = 5'h0B;
      8'h3B: n = 5'h0C;
      8'h43: n = 5'h0D;
      8'h42: n = 5'h0E;
      8'h44: n = 5'h0F;
      8'h4B: n = 5'h10;
      8'h4D: n = 5'h11;
      8'h4C: n = 5'h12;
      8'h52: n = 5'h13;
      default: n = 5'h00;
    endcase
    return n;
  endfunction
  assign keyIdx = keyOf(ps2Shift_r[8:1]);
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ps2ClkD_r <= 1'b1;
      ps2Shift_r <= 11'h000;
      ps2Bits_r <= 4'h0;
      breakPend_r <= 1'b0;
      pressed_r <= '0;
    end else begin
      ps2ClkD_r <= ps2ClkS;
      if (ps2ClkD_r && !ps2ClkS) begin
        ps2Shift_r <= {ps2DataS, ps2Shift_r[10:1]};
        ps2Bits_r <= (ps2Bits_r == 4'hA) ? 4'h0 : ps2Bits_r + 4'h1;
      end else if (ps2Bits_r == 4'h0 && ps2Shift_r[10]) begin
        ps2Shift_r <= 11'h000;
        if (ps2Shift_r[8:1] == `KMS_PS2_BREAK) begin
          breakPend_r <= 1'b1;
        end else if (ps2Shift_r[8:1] != 8'hE0) begin
          breakPend_r <= 1'b0;
          if (keyIdx != 5'h00) begin
            pressed_r[keyIdx - 5'h01] <= !breakPend_r;
          end
        end
      end
    end
  end
  kms_note_t keyNote;
  always_comb begin
    keyNote = 5'h00;
    for (int i = `KMS_NUM_KEYS - 1; i >= 0; i--) begin
      if (pressed_r[i]) begin
        keyNote = 5'(i + 1);
      end
    end
  end

  // ==========================================================
  // demo melody player
  logic [3:0] demoPos_r;
  logic [31:0] demoCnt_r;
  logic playing_r, replayD_r, swReplay_r, muted_r;
  kms_note_t demoNote;
  function automatic kms_note_t tuneAt(input logic [3:0] p);
    kms_note_t n;
    n = 5'h00;
    unique case (p)
      4'h0, 4'h1, 4'hE: n = 5'h07;
      4'h2, 4'h3, 4'h6: n = 5'h0E;
      4'h4, 4'h5: n = 5'h10;
      4'h8, 4'h9: n = 5'h0C;
      4'hA, 4'hB: n = 5'h0B;
      4'hC, 4'hD: n = 5'h09;
      default: n = 5'h00;
    endcase
    return n;
  endfunction
  assign demoNote = playing_r ? tuneAt(demoPos_r) : 5'h00;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      replayD_r <= 1'b1;
      playing_r <= 1'b0;
      demoPos_r <= 4'h0;
      demoCnt_r <= 32'h0;
    end else begin
      replayD_r <= replayS_b;
      if ((replayD_r && !replayS_b) || swReplay_r) begin
        playing_r <= 1'b1;
        demoPos_r <= 4'h0;
        demoCnt_r <= 32'h0;
      end else if (playing_r && !sourceSw) begin
        if (demoCnt_r == 32'(DEMO_STEP_CYCLES - 1)) begin
          demoCnt_r <= 32'h0;
          demoPos_r <= demoPos_r + 4'h1;
          playing_r <= (demoPos_r != 4'(`KMS_DEMO_LEN - 1));
        end else begin
          demoCnt_r <= demoCnt_r + 32'h1;
        end
      end
    end
  end

  // ==========================================================
  // synth core
  kms_note_if noteIf ();
  assign noteIf.note = muted_r ? 5'h00 : (sourceSw ? keyNote : demoNote);
  assign noteIf.timbre = timbreSw ? KMS_STRING : KMS_BRASS;
  kms_timbre_synth_core uSynth (
    .core_clk(core_clk),
    .rstN(rstN),
    .noteIf(noteIf)
  );

  // ==========================================================
  // codec stream, 64 bit clocks per frame, left while lrck is low
  logic [4:0] bclkDiv_r;
  logic [5:0] bitIdx_r;
  logic [31:0] frame_r;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      bclkDiv_r <= 5'h00;
      bitIdx_r <= 6'h00;
      frame_r <= 32'h0;
      audBclk <= 1'b0;
      audLrck <= 1'b0;
      audDacData <= 1'b0;
    end else if (bclkDiv_r == `KMS_BCLK_HALF - 5'h01) begin
      bclkDiv_r <= 5'h00;
      audBclk <= !audBclk;
      if (audBclk) begin
        bitIdx_r <= bitIdx_r + 6'h01;
        audLrck <= bitIdx_r[5];
        if (bitIdx_r == 6'h00) begin
          frame_r <= {(chOneSw ? noteIf.sample : 16'h0000),
                      (chTwoSw ? noteIf.sample : 16'h0000)};
          audDacData <= chOneSw & noteIf.sample[15];
        end else if (bitIdx_r == 6'h20) begin
          audDacData <= frame_r[15];
        end else if (bitIdx_r[4] == 1'b0) begin
          audDacData <= bitIdx_r[5] ? frame_r[5'h0F - {1'b0, bitIdx_r[3:0]}] : frame_r[31 - 32'(bitIdx_r[3:0])];
        end else begin
          audDacData <= 1'b0;
        end
      end
    end else begin
      bclkDiv_r <= bclkDiv_r + 5'h01;
    end
  end

  // ==========================================================
  // vga key picture
  logic [1:0] pixDiv_r;
  logic [9:0] hCnt_r, vCnt_r;
  logic [`KMS_NUM_KEYS-1:0] shown;
  logic inKeys, keyLit, keyEdge;
  assign shown = sourceSw ? pressed_r : ((demoNote != 5'h00) ? (19'h1 << (demoNote - 5'h01)) : '0);
  assign inKeys = (vCnt_r >= `KMS_KEY_TOP) && (vCnt_r < `KMS_KEY_BOT) && (hCnt_r < 10'(`KMS_NUM_KEYS * 32));
  assign keyEdge = (hCnt_r[4:0] == 5'h00);
  assign keyLit = inKeys && shown[hCnt_r[9:5]];
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      pixDiv_r <= 2'h0;
      hCnt_r <= 10'h000;
      vCnt_r <= 10'h000;
      vgaHsync <= 1'b1;
      vgaVsync <= 1'b1;
      {vgaRed, vgaGreen, vgaBlue} <= 3'h0;
    end else begin
      pixDiv_r <= pixDiv_r + 2'h1;
      if (pixDiv_r == `KMS_PIX_DIV) begin
        hCnt_r <= (hCnt_r == `KMS_H_TOTAL) ? 10'h000 : hCnt_r + 10'h001;
        if (hCnt_r == `KMS_H_TOTAL) begin
          vCnt_r <= (vCnt_r == `KMS_V_TOTAL) ? 10'h000 : vCnt_r + 10'h001;
        end
      end
      vgaHsync <= !((hCnt_r >= `KMS_H_SYNC_ON) && (hCnt_r < `KMS_H_SYNC_OFF));
      vgaVsync <= !((vCnt_r >= `KMS_V_SYNC_ON) && (vCnt_r < `KMS_V_SYNC_OFF));
      if (!inKeys || keyEdge) begin
        {vgaRed, vgaGreen, vgaBlue} <= 3'h0;
      end else begin
        {vgaRed, vgaGreen, vgaBlue} <= keyLit ? 3'h4 : 3'h7;
      end
    end
  end

  // ==========================================================
  // axi4-lite slave
  logic awHave_r, wHave_r;
  logic [5:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 6'h00;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      swReplay_r <= 1'b0;
      muted_r <= 1'b0;
    end else begin
      swReplay_r <= 1'b0;
      s_axi_awready <= !awHave_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !wHave_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (awHave_r && wHave_r && !s_axi_bvalid) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r[5:2] <= 4'h2 && awAddr_r[1:0] == 2'h0) ? 2'h0 : 2'h2;
        if (awAddr_r == `KMS_ADDR_CTRL && wStrb_r[0]) begin
          swReplay_r <= wData_r[`KMS_CTRL_REPLAY];
          muted_r <= wData_r[`KMS_CTRL_MUTE];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr)
          `KMS_ADDR_CTRL: s_axi_rdata <= {30'h0, muted_r, 1'b0};
          `KMS_ADDR_STATUS: s_axi_rdata <= {pressed_r, 3'h0, playing_r, sourceSw, noteIf.note, 3'h0};
          `KMS_ADDR_DEMO: s_axi_rdata <= {28'h0, demoPos_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* dv/kms_top_chk.sv */
// Purpose: pin-level checks of kms_top
// Assumes: one clock domain, rst_b active low
// Notes: bound into every kms_top below
module kms_top_chk #(
  parameter int DEMO_STEP_CYCLES = 50
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // switches
  input wire logic channel_one_enable_switch,
  input wire logic channel_two_enable_switch,
  // audio and vga
  input wire logic audBclk,
  input wire logic audDacData,
  input wire logic vgaHsync,
  input wire logic vgaRed,
  input wire logic vgaGreen,
  input wire logic vgaBlue,
  // axi4-lite
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================
  // cycles with both channels off
  logic [11:0] offCnt_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      offCnt_r <= 12'h000;
    end else if (channel_one_enable_switch || channel_two_enable_switch) begin
      offCnt_r <= 12'h000;
    end else if (offCnt_r != 12'hFFF) begin
      offCnt_r <= offCnt_r + 12'h001;
    end
  end
  // ==========================================
  // properties
  property p_bclk; $rose(audBclk) |-> ##16 $fell(audBclk); endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock high time wrong");
  property p_quiet; offCnt_r > 12'h900 |-> !audDacData; endproperty
  a_quiet: assert property (p_quiet) else $error("audio not silent");
  property p_hsw; $fell(vgaHsync) |-> ##[384:384] $rose(vgaHsync); endproperty
  a_hsw: assert property (p_hsw) else $error("hsync width wrong");
  property p_dark; !vgaHsync |-> !(vgaRed || vgaGreen || vgaBlue); endproperty
  a_dark: assert property (p_dark) else $error("colour during hsync");
  property p_pal; vgaGreen || vgaBlue |-> vgaRed && vgaGreen && vgaBlue; endproperty
  a_pal: assert property (p_pal) else $error("colour not red white or black");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer not held");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_blat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  c_write: cover property (s_axi_bvalid);
  c_slverr: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'b10);
  c_quiet: cover property (offCnt_r > 12'h900 && audBclk);
endmodule

bind kms_top kms_top_chk #(.DEMO_STEP_CYCLES(DEMO_STEP_CYCLES)) chk (.*);

/* dv/kms_ps2_kbd.sv */
// Purpose: keyboard side of the ps2 link
// Assumes: lines pulled up when idle
// Notes: clock runs only within a frame
module kms_ps2_kbd #(
  parameter int HALF = 20
) (
  // ps2 lines
  output logic ps2Clk,
  output logic ps2Data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ps2Clk = 1'b1;
    ps2Data = 1'b1;
  end
  // start, eight bits lsb first, odd parity, stop
  task automatic send(input logic [7:0] c);
    logic [10:0] f;
    f = {1'b1, ~^c, c, 1'b0};
    #3;
    for (int i = 0; i < 11; i++) begin
      ps2Data = f[i];
      #(HALF * 10);
      ps2Clk = 1'b0;
      #(HALF * 10);
      ps2Clk = 1'b1;
    end
    ps2Data = 1'b1;
    #(HALF * 20);
  endtask
endmodule

/* dv/tb_kms_top.sv */
// Purpose: self-checking bench of kms_top
// Assumes: demo step shortened, fast keyboard frames
// Notes: register answers are noted in queues and checked by a monitor
`include "kms_defs.svh"
module tb_kms_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 50;
  localparam logic [31:0] SMASK = 32'hFFFFE1F8;
  localparam logic [7:0] KEYS [19] = '{8'h15, 8'h1C, 8'h1D, 8'h1B, 8'h24, 8'h23, 8'h2B, 8'h2C, 8'h34, 8'h35,
    8'h33, 8'h3B, 8'h43, 8'h42, 8'h44, 8'h4B, 8'h4D, 8'h4C, 8'h52};
  logic core_clk, rst_b, timbre_select_switch, source_select_switch, replayBtn_b, ps2Clk, ps2Data;
  logic channel_one_enable_switch, channel_two_enable_switch;
  logic audBclk, audLrck, audDacData, vgaHsync, vgaVsync, vgaRed, vgaGreen, vgaBlue;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] w0, w1;
  logic [65:0] re;
  logic [1:0] bq[$];
  logic [65:0] rq[$];
  int error_cnt, cmp_count;

  kms_top #(.DEMO_STEP_CYCLES(STEP)) uut (.*);
  kms_ps2_kbd kbd (.ps2Clk(ps2Clk), .ps2Data(ps2Data));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [15:0] sq(input logic [15:0] v);
    return (v === `KMS_SQ_LOW) ? `KMS_SQ_LOW : `KMS_SQ_HIGH;
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic cmp_w(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      bound(n, 200);
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    int n;
    n = 0;
    rq.push_back({r, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      seed = xs(seed);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= seed[0];
      n++;
      bound(n, 200);
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask
  task automatic press();
    replayBtn_b <= 1'b0;
    tick(4);
    replayBtn_b <= 1'b1;
  endtask
  // one left-justified word of channel ch, msb first on bit clock rise
  task automatic grab(input logic ch, output logic [15:0] w);
    int n;
    int i;
    logic pb;
    n = 0;
    i = 0;
    w = 16'h0000;
    for (int k = 0; k < 2; k++) begin
      while (audLrck !== (ch ^ (k == 0)) && n < 6000) begin
        @(posedge core_clk);
        n++;
      end
    end
    while (i < 16 && n < 6000) begin
      pb = audBclk;
      @(posedge core_clk);
      n++;
      if (audBclk && !pb) begin
        w = {w[14:0], audDacData};
        i++;
      end
    end
    bound(n, 6000);
  endtask
  // ==========================================
  // monitor of bus answers
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      cmp_w({30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      cmp_w(re[31:0] & re[63:32], s_axi_rdata & re[63:32]);
      cmp_w({30'h0, re[65:64]}, {30'h0, s_axi_rresp});
    end
  end
  // ==========================================
  // main sequence
  initial begin
    {rst_b, timbre_select_switch, source_select_switch, channel_one_enable_switch, channel_two_enable_switch} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'hF;
    replayBtn_b = 1'b1;
    seed = 32'h00000010;
    error_cnt = 0;
    cmp_count = 0;
    tick(12);
    rst_b <= 1'b1;
    tick(8);
    rd(6'h00, 32'h0, 32'hFFFFFFFF, 2'b00);
    rd(6'h04, 32'h0, 32'hFFFFFFFF, 2'b00);
    rd(6'h08, 32'h0, 32'h0000000F, 2'b00);
    rd(6'h10, 32'h0, 32'hFFFFFFFF, 2'b10);
    rd(6'h02, 32'h0, 32'hFFFFFFFF, 2'b10);
    wr(6'h3C, 32'h1, 2'b10);
    wr(6'h00, 32'h2, 2'b00);
    rd(6'h00, 32'h2, 32'h00000002, 2'b00);
    wr(6'h00, 32'h0, 2'b00);
    press();
    tick(8 * STEP);
    rd(6'h04, 32'h200, 32'h00000200, 2'b00);
    wr(6'h00, 32'h1, 2'b00);
    rd(6'h08, 32'h0, 32'h0000000F, 2'b00);
    tick(40 * STEP);
    rd(6'h04, 32'h0, 32'h00000200, 2'b00);
    press();
    tick(4 * STEP);
    rst_b <= 1'b0;
    tick(3);
    rst_b <= 1'b1;
    tick(8);
    rd(6'h08, 32'h0, 32'h0000000F, 2'b00);
    rd(6'h04, 32'h0, 32'h00000200, 2'b00);
    source_select_switch <= 1'b1;
    {channel_one_enable_switch, channel_two_enable_switch} <= 2'b11;
    tick(4);
    grab(1'b0, w0);
    cmp_w(32'h0, {16'h0, w0});
    for (int i = 0; i < 19; i++) begin
      kbd.send(KEYS[i]);
      tick(4);
      rd(6'h04, (32'h1 << (13 + i)) | 32'h100 | 32'((i + 1) << 3), SMASK, 2'b00);
      kbd.send(8'hF0);
      kbd.send(KEYS[i]);
      tick(4);
      rd(6'h04, 32'h100, SMASK, 2'b00);
    end
    kbd.send(KEYS[6]);
    tick(1);
    {channel_one_enable_switch, channel_two_enable_switch} <= 2'b01;
    tick(2100);
    grab(1'b0, w0);
    cmp_w(32'h0, {16'h0, w0});
    grab(1'b1, w1);
    cmp_w({16'h0, sq(w1)}, {16'h0, w1});
    {channel_one_enable_switch, channel_two_enable_switch} <= 2'b10;
    tick(2100);
    grab(1'b0, w0);
    cmp_w({16'h0, sq(w0)}, {16'h0, w0});
    grab(1'b1, w1);
    cmp_w(32'h0, {16'h0, w1});
    timbre_select_switch <= 1'b1;
    tick(2100);
    grab(1'b0, w0);
    grab(1'b0, w1);
    cmp_w(32'h1, {31'h0, (w0 !== sq(w0)) || (w1 !== sq(w1))});
    cmp_w(32'h1, {31'h0, vgaVsync});
    tally_and_finish();
  end
endmodule
